// ===== hw/ers_monitor.sv
// error rate monitor: interval results, lock tracking, apb registers
`timescale 1ns/1ps
module ers_monitor #(
   parameter int unsigned IV_CYC = ers_pkg::IV_BASE_CYC  // 100 ms in clocks
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // compared bit stream
   input  wire logic        bit_valid,   // one compared bit this clock
   input  wire logic        bit_err,     // that bit was in error
   // status outputs
   output logic             sync_locked, // lock state
   output logic             resync_start,// one-cycle realign request
   output logic             result_stb,  // one-cycle new result pulse
   output logic      [31:0] result_err,  // reported error count
   output logic      [31:0] result_clk   // reported clock count
);
   import ers_pkg::*;

   // whole state of the block
   typedef struct packed {
      logic [31:0] ctrl;     // control register
      logic [31:0] dlen;     // data length register
      logic [31:0] period;   // intervals per period
      logic [31:0] prdata;   // read data captured in setup
      logic [31:0] iv_tmr;   // clock cycles into the interval
      logic [31:0] iv_idx;   // intervals into the period
      logic [31:0] iv_err;   // errors this interval
      logic [31:0] iv_clk;   // bits this interval
      logic [31:0] tot_err;  // errors since period start
      logic [31:0] tot_clk;  // bits since period start
      logic [31:0] res_err;  // reported errors
      logic [31:0] res_clk;  // reported bits
      logic [31:0] res_seq;  // report counter
      logic        res_stb;  // report pulse
      logic [31:0] win_err;  // errors in sync window
      logic [31:0] win_clk;  // bits in sync window
      ers_sync_t   sync;     // lock state
      logic        resync;   // realign pulse
      logic [7:0]  rs_cnt;   // realign count
   } ers_state_t;

   ers_state_t  q;         // registered state
   ers_state_t  d;         // next state
   logic [31:0] loss_win;  // selected loss window
   logic [31:0] loss_lim;  // selected loss limit
   logic [31:0] gain_win;  // selected gain window
   logic [31:0] gain_lim;  // selected gain limit
   logic [31:0] e_inc;     // error of this clock
   logic [31:0] c_inc;     // bit of this clock
   logic [31:0] iv_len;    // interval length in clocks
   logic [31:0] w_err;     // window errors including this clock
   logic [31:0] w_clk;     // window bits including this clock
   logic        iv_end;    // last clock of interval
   logic        per_end;   // last interval of period
   logic        addr_ok;   // address is mapped
   logic        wr_acc;    // write access phase

   // threshold selection
   ers_thresh u_thresh (
      .use_table (q.ctrl[CB_THRTAB]),
      .exp_n     (q.ctrl[CB_N_LO +: CB_N_W]),
      .szp       (q.ctrl[CB_SZP]),
      .data_len  (q.dlen),
      .loss_win  (loss_win),
      .loss_lim  (loss_lim),
      .gain_win  (gain_win),
      .gain_lim  (gain_lim)
   );

   // apb decode, slave always ready
   // pready tied high, so every access phase lasts one cycle
   always_comb begin
      addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_DLEN) ||
                (paddr == OFS_PERIOD) || (paddr == OFS_STATUS) ||
                (paddr == OFS_RERR) || (paddr == OFS_RCLK) ||
                (paddr == OFS_RSEQ);
      wr_acc  = psel && penable && pwrite;
      pready  = 1'b1;
      pslverr = psel && penable && !addr_ok;
   end

   // next-state logic
   always_comb begin
      d         = q;
      d.res_stb = 1'b0;
      d.resync  = 1'b0;
      e_inc     = {31'h0000_0000, bit_valid && bit_err};
      c_inc     = {31'h0000_0000, bit_valid};
      iv_len    = q.ctrl[CB_IV200] ? 32'(IV_CYC * 2) : 32'(IV_CYC);
      iv_end    = (q.iv_tmr == 32'(iv_len - 32'h0000_0001));
      per_end   = iv_end && (32'(q.iv_idx + 32'h0000_0001) >= q.period);
      w_err     = 32'(q.win_err + e_inc);
      w_clk     = 32'(q.win_clk + c_inc);

      // register writes, read-only offsets ignore writes
      if (wr_acc) begin
         unique case (paddr)
            OFS_CTRL:   d.ctrl   = pwdata & CTRL_WMASK;
            OFS_DLEN:   d.dlen   = pwdata;
            OFS_PERIOD: d.period = pwdata;
            default:    d.ctrl   = q.ctrl;
         endcase
      end

      // read data captured in setup phase, unmapped reads zero
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFS_CTRL:   d.prdata = q.ctrl;
            OFS_DLEN:   d.prdata = q.dlen;
            OFS_PERIOD: d.prdata = q.period;
            OFS_STATUS: d.prdata = {16'h0000, q.rs_cnt, 7'h00, q.sync};
            OFS_RERR:   d.prdata = q.res_err;
            OFS_RCLK:   d.prdata = q.res_clk;
            OFS_RSEQ:   d.prdata = q.res_seq;
            default:    d.prdata = 32'h0000_0000;
         endcase
      end

      // measurement accumulation and reporting
      // run low holds the interval and total counters at zero, so a new run starts clean
      if (!q.ctrl[CB_RUN]) begin
         d.iv_tmr  = 32'h0000_0000;
         d.iv_idx  = 32'h0000_0000;
         d.iv_err  = 32'h0000_0000;
         d.iv_clk  = 32'h0000_0000;
         d.tot_err = 32'h0000_0000;
         d.tot_clk = 32'h0000_0000;
      end else begin
         d.iv_err  = 32'(q.iv_err + e_inc);
         d.iv_clk  = 32'(q.iv_clk + c_inc);
         d.tot_err = 32'(q.tot_err + e_inc);
         d.tot_clk = 32'(q.tot_clk + c_inc);
         d.iv_tmr  = 32'(q.iv_tmr + 32'h0000_0001);
         if (iv_end) begin
            d.iv_tmr = 32'h0000_0000;
            d.iv_idx = 32'(q.iv_idx + 32'h0000_0001);
            if (q.ctrl[CB_LIVE]) begin
               d.res_stb = 1'b1;
               if (q.ctrl[CB_VIEWIV]) begin
                  d.res_err = d.iv_err;
                  d.res_clk = d.iv_clk;
               end else begin
                  d.res_err = d.tot_err;
                  d.res_clk = d.tot_clk;
               end
            end
            d.iv_err = 32'h0000_0000;
            d.iv_clk = 32'h0000_0000;
            // totals restart each period; a live report has been taken already
            if (per_end) begin
               if (!q.ctrl[CB_LIVE]) begin
                  d.res_stb = 1'b1;
                  d.res_err = d.tot_err;
                  d.res_clk = d.tot_clk;
               end
               d.iv_idx  = 32'h0000_0000;
               d.tot_err = 32'h0000_0000;
               d.tot_clk = 32'h0000_0000;
            end
         end
      end
      if (d.res_stb) begin
         d.res_seq = 32'(q.res_seq + 32'h0000_0001);
      end

      // lock tracking, decided only at window end
      // idle clocks carry no bit, so they do not dilute the rate
      d.win_err = w_err;
      d.win_clk = w_clk;
      unique case (q.sync)
         ERS_LOCKED: begin
            if (w_clk >= loss_win) begin
               d.win_err = 32'h0000_0000;
               d.win_clk = 32'h0000_0000;
               if (w_err > loss_lim) begin
                  d.sync = ERS_UNLOCKED;
                  if (q.ctrl[CB_AUTO]) begin
                     d.resync = 1'b1;
                     d.rs_cnt = 8'(q.rs_cnt + 8'h01);
                  end
               end
            end
         end
         ERS_UNLOCKED: begin
            if (w_clk >= gain_win) begin
               d.win_err = 32'h0000_0000;
               d.win_clk = 32'h0000_0000;
               if (w_err <= gain_lim) begin
                  d.sync = ERS_LOCKED;
               end
            end
         end
      endcase
   end

   // state register, synchronous reset
   // control, data length and period registers take their reset values, everything else clears
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         q        <= '0;
         q.ctrl   <= CTRL_RST;
         q.dlen   <= DLEN_RST;
         q.period <= PERIOD_RST;
         q.sync   <= ERS_UNLOCKED;
      end else begin
         q <= d;
      end
   end

   // outputs from flip-flops
   assign prdata       = q.prdata;
   assign sync_locked  = (q.sync == ERS_LOCKED);
   assign resync_start = q.resync;
   assign result_stb   = q.res_stb;
   assign result_err   = q.res_err;
   assign result_clk   = q.res_clk;

   // checks: lock decisions and reported error bound
   a_loss_above: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_LOCKED && w_clk >= loss_win && w_err > loss_lim)
      |=> !sync_locked)
      else $error("lock kept although errors exceeded loss limit");
   a_loss_hold: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_LOCKED && w_err <= loss_lim) |=> sync_locked)
      else $error("lock dropped while errors within loss limit");
   a_gain_at: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_UNLOCKED && w_clk >= gain_win && w_err <= gain_lim)
      |=> sync_locked)
      else $error("lock not gained at or below gain limit");
   a_gain_midwin: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_UNLOCKED && w_clk < gain_win) |=> !sync_locked)
      else $error("lock gained before window end");
   a_lock_midwin: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_LOCKED && w_clk < loss_win) |=> sync_locked)
      else $error("lock lost before window end");
   a_loss_restart: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_LOCKED && w_clk >= loss_win) |=> (q.win_clk == 32'h0000_0000))
      else $error("window not restarted after loss decision");
   a_gain_restart: assert property (@(posedge clock) disable iff (!rst_b)
      (q.sync == ERS_UNLOCKED && w_clk >= gain_win) |=> (q.win_clk == 32'h0000_0000))
      else $error("window not restarted after gain decision");
   a_err_bound: assert property (@(posedge clock) disable iff (!rst_b)
      result_err <= result_clk)
      else $error("reported errors exceed reported clocks");

   // checks: realignment
   a_auto_resync: assert property (@(posedge clock) disable iff (!rst_b)
      ($fell(sync_locked) && $past(q.ctrl[CB_AUTO])) |-> resync_start)
      else $error("no realign on lock loss with auto on");
   a_no_resync: assert property (@(posedge clock) disable iff (!rst_b)
      resync_start |-> ($fell(sync_locked) && $past(q.ctrl[CB_AUTO])))
      else $error("realign without enabled lock loss");
   a_resync_pulse: assert property (@(posedge clock) disable iff (!rst_b)
      resync_start |=> !resync_start)
      else $error("realign request longer than one cycle");
   a_resync_count: assert property (@(posedge clock) disable iff (!rst_b)
      resync_start |-> (q.rs_cnt == 8'($past(q.rs_cnt) + 8'h01)))
      else $error("realign count did not step with a realign");

   // checks: result reporting
   a_live_iv: assert property (@(posedge clock) disable iff (!rst_b)
      (q.ctrl[CB_RUN] && q.ctrl[CB_LIVE] && iv_end) |=> result_stb)
      else $error("no live report at interval end");
   a_run_quiet: assert property (@(posedge clock) disable iff (!rst_b)
      !q.ctrl[CB_RUN] |=> !result_stb)
      else $error("report published while not running");
   a_seq_step: assert property (@(posedge clock) disable iff (!rst_b)
      result_stb |-> (q.res_seq == 32'($past(q.res_seq) + 32'h0000_0001)))
      else $error("report counter did not step with a report");
   a_iv_view: assert property (@(posedge clock) disable iff (!rst_b)
      (q.ctrl[CB_RUN] && q.ctrl[CB_LIVE] && q.ctrl[CB_VIEWIV] && iv_end)
      |=> (result_err == 32'($past(q.iv_err) + $past(e_inc))))
      else $error("interval view reported wrong errors");
   a_run_view: assert property (@(posedge clock) disable iff (!rst_b)
      (q.ctrl[CB_RUN] && q.ctrl[CB_LIVE] && !q.ctrl[CB_VIEWIV] && iv_end)
      |=> (result_clk == 32'($past(q.tot_clk) + $past(c_inc))))
      else $error("running view reported wrong clocks");
   a_hold_off: assert property (@(posedge clock) disable iff (!rst_b)
      (!q.ctrl[CB_LIVE] && !per_end) |=> $stable(result_err))
      else $error("held result changed before period end");
   a_hold_clk: assert property (@(posedge clock) disable iff (!rst_b)
      (!q.ctrl[CB_LIVE] && !per_end) |=> $stable(result_clk))
      else $error("held clock count changed before period end");

   // cover the main scenarios
   c_loss: cover property (@(posedge clock) disable iff (!rst_b)
      $fell(sync_locked));
   c_gain: cover property (@(posedge clock) disable iff (!rst_b)
      $rose(sync_locked));
   c_period: cover property (@(posedge clock) disable iff (!rst_b)
      q.ctrl[CB_RUN] && !q.ctrl[CB_LIVE] && per_end);
   c_live: cover property (@(posedge clock) disable iff (!rst_b)
      q.ctrl[CB_RUN] && q.ctrl[CB_LIVE] && iv_end);
   c_resync: cover property (@(posedge clock) disable iff (!rst_b)
      resync_start);

endmodule : ers_monitor

// ===== hw/ers_pkg.sv
// constants, register map and types shared by the error rate / sync monitor
// How it works
// - live refresh each interval, 100 or 200 ms
// - live refresh shows running total or last interval
// - running view sums counts since period start
// - interval view shows last interval only
// - live off holds last period result
// - auto realign only when enabled, on loss
// - threshold is ten power minus N or table
// - locked goes unlocked above loss threshold
// - unlocked goes locked at or below gain
// - short patterns: loss 2000/5000, gain 1/4
// - length 17-160: loss 400/5000, gain 1/40
// - length 161-1600: loss 40/5000, gain 1/400
// - length 1601-16000: loss 4/5000
// - length to 80000: loss 4/25000, gain 1/10000
// - length to 160000: loss 4/50000, gain 1/20000
// - rate is errors over clocks in window
package ers_pkg;

   // clock and interval timing
   localparam int unsigned CLK_HZ      = 40_000_000;  // system clock rate
   localparam int unsigned IV_BASE_MS  = 100;         // short interval, ms
   localparam int unsigned IV_BASE_CYC = IV_BASE_MS * (CLK_HZ / 1000);

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;  // control bits
   localparam logic [7:0] OFS_DLEN   = 8'h04;  // data length of pattern
   localparam logic [7:0] OFS_PERIOD = 8'h08;  // intervals per period
   localparam logic [7:0] OFS_STATUS = 8'h0C;  // lock state, realign count
   localparam logic [7:0] OFS_RERR   = 8'h10;  // reported error count
   localparam logic [7:0] OFS_RCLK   = 8'h14;  // reported clock count
   localparam logic [7:0] OFS_RSEQ   = 8'h18;  // report sequence number

   // control field positions
   localparam int unsigned CB_RUN    = 0;   // measurement running
   localparam int unsigned CB_LIVE   = 1;   // live view on
   localparam int unsigned CB_VIEWIV = 2;   // per-interval view
   localparam int unsigned CB_IV200  = 3;   // 200 ms interval
   localparam int unsigned CB_AUTO   = 4;   // automatic realignment
   localparam int unsigned CB_THRTAB = 5;   // table thresholds
   localparam int unsigned CB_N_LO   = 8;   // exponent field, 4 bits
   localparam int unsigned CB_N_W    = 4;   // exponent field width
   localparam int unsigned CB_SZP    = 12;  // substituted_zero_pattern
   localparam logic [31:0] CTRL_WMASK = 32'h0000_1F3F;

   // reset values
   localparam logic [31:0] CTRL_RST   = 32'h0000_0220;
   localparam logic [31:0] DLEN_RST   = 32'h0000_0002;
   localparam logic [31:0] PERIOD_RST = 32'h0000_0005;

   // threshold units and table rows
   localparam logic [31:0] WIN_UNIT  = 32'h0000_1000;  // 4,096 clocks
   localparam logic [31:0] LIM_UNIT  = 32'h0000_0100;  // 256 errors
   localparam logic [31:0] LEN_R1    = 32'd16;
   localparam logic [31:0] LEN_R2    = 32'd160;
   localparam logic [31:0] LEN_R3    = 32'd1_600;
   localparam logic [31:0] LEN_R4    = 32'd16_000;
   localparam logic [31:0] LEN_R5    = 32'd80_000;
   localparam logic [31:0] LOSS_E_A  = 32'd2_000;
   localparam logic [31:0] LOSS_E_B  = 32'd400;
   localparam logic [31:0] LOSS_E_C  = 32'd40;
   localparam logic [31:0] LOSS_E_D  = 32'd4;
   localparam logic [31:0] LOSS_W_A  = 32'd5_000;
   localparam logic [31:0] LOSS_W_B  = 32'd25_000;
   localparam logic [31:0] LOSS_W_C  = 32'd50_000;
   localparam logic [31:0] GAIN_W_A  = 32'd4;
   localparam logic [31:0] GAIN_W_B  = 32'd40;
   localparam logic [31:0] GAIN_W_C  = 32'd400;
   localparam logic [31:0] GAIN_W_D  = 32'd10_000;
   localparam logic [31:0] GAIN_W_E  = 32'd20_000;

   // decimal thresholds: window of DEC_LIM*10^N clocks, DEC_LIM errors
   localparam logic [31:0] DEC_LIM   = 32'h0000_0010;
   localparam logic [31:0] DEC_BASE  = 32'h0000_000A;
   localparam logic [3:0]  N_MIN     = 4'h2;
   localparam logic [3:0]  N_MAX     = 4'h8;

   // lock state
   typedef enum logic [0:0] {
      ERS_UNLOCKED = 1'b0,
      ERS_LOCKED   = 1'b1
   } ers_sync_t;

endpackage : ers_pkg

// ===== hw/ers_thresh.sv
// threshold window and error limit selection for lock and loss decisions
`timescale 1ns/1ps
module ers_thresh (
   // threshold selection
   input  wire logic        use_table,  // length table instead of 10^-N
   input  wire logic [3:0]  exp_n,      // N of 10^-N
   input  wire logic        szp,        // substituted_zero_pattern selected
   input  wire logic [31:0] data_len,   // pattern data length
   // selected thresholds
   output logic      [31:0] loss_win,   // loss window, clocks
   output logic      [31:0] loss_lim,   // loss when errors exceed this
   output logic      [31:0] gain_win,   // gain window, clocks
   output logic      [31:0] gain_lim    // gain when errors at or below
);
   import ers_pkg::*;

   logic [3:0]  n_eff;  // exponent clamped into its legal range
   logic [31:0] pow;    // DEC_LIM * 10^N

   // row lookup and decimal threshold
   always_comb begin
      n_eff = exp_n;
      if (exp_n < N_MIN) begin
         n_eff = N_MIN;
      end else if (exp_n > N_MAX) begin  // field values above 8 act as 8
         n_eff = N_MAX;
      end
      pow = DEC_LIM;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n_eff) begin
            pow = 32'(pow * DEC_BASE);
         end
      end
      if (!use_table) begin
         loss_win = pow;
         loss_lim = DEC_LIM;
         gain_win = pow;
         gain_lim = DEC_LIM;
      end else begin
         gain_lim = LIM_UNIT;
         if (!szp || data_len <= LEN_R1) begin
            loss_win = 32'(WIN_UNIT * LOSS_W_A);
            loss_lim = 32'(LIM_UNIT * LOSS_E_A);
            gain_win = 32'(WIN_UNIT * GAIN_W_A);
         end else if (data_len <= LEN_R2) begin
            loss_win = 32'(WIN_UNIT * LOSS_W_A);
            loss_lim = 32'(LIM_UNIT * LOSS_E_B);
            gain_win = 32'(WIN_UNIT * GAIN_W_B);
         end else if (data_len <= LEN_R3) begin
            loss_win = 32'(WIN_UNIT * LOSS_W_A);
            loss_lim = 32'(LIM_UNIT * LOSS_E_C);
            gain_win = 32'(WIN_UNIT * GAIN_W_C);
         end else if (data_len <= LEN_R4) begin
            loss_win = 32'(WIN_UNIT * LOSS_W_A);
            loss_lim = 32'(LIM_UNIT * LOSS_E_D);
            gain_win = 32'(WIN_UNIT * GAIN_W_C);
         end else if (data_len <= LEN_R5) begin
            loss_win = 32'(WIN_UNIT * LOSS_W_B);
            loss_lim = 32'(LIM_UNIT * LOSS_E_D);
            gain_win = 32'(WIN_UNIT * GAIN_W_D);
         end else begin  // longer lengths use this row too
            loss_win = 32'(WIN_UNIT * LOSS_W_C);
            loss_lim = 32'(LIM_UNIT * LOSS_E_D);
            gain_win = 32'(WIN_UNIT * GAIN_W_E);
         end
      end
   end

endmodule : ers_thresh

// ===== verification/tb_top.sv
// self-checking testbench for the error rate and sync monitor
`timescale 1ns/1ps
module tb_top;
   import ers_pkg::*;
   localparam int unsigned IV = 20;  // shortened interval length in clocks
   logic        clock;               // system clock
   logic        rst_b;               // synchronous reset, active low
   logic [7:0]  paddr;               // apb address
   logic        psel;                // apb select
   logic        penable;             // apb enable
   logic        pwrite;              // apb direction
   logic [31:0] pwdata;              // apb write data
   logic [31:0] prdata;              // apb read data
   logic        pready;              // apb ready
   logic        pslverr;             // apb error
   logic        bit_valid;           // compared bit present
   logic        bit_err;             // compared bit in error
   logic        sync_locked;         // lock state
   logic        resync_start;        // realign pulse
   logic        result_stb;          // new result pulse
   logic [31:0] result_err;          // reported errors
   logic [31:0] result_clk;          // reported clocks
   int          errors;              // mismatches
   int          n_tests;             // comparisons
   int          n_resync;            // realign pulses seen
   logic        stream_on;           // free running stream enable

   ers_monitor #(.IV_CYC(IV)) u_dut (
      .clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bit_valid(bit_valid), .bit_err(bit_err),
      .sync_locked(sync_locked), .resync_start(resync_start), .result_stb(result_stb),
      .result_err(result_err), .result_clk(result_clk));

   // clock generator
   always #12.5 clock = ~clock;

   // free running stream: every clock a bit, every second bit in error
   always @(posedge clock) begin
      if (stream_on) begin
         bit_valid <= 1'b1;
         bit_err   <= ~bit_err;
      end
   end

   // count realign pulses where outputs have settled
   always @(negedge clock) begin
      if (resync_start === 1'b1) n_resync++;
   end

   // compare and report
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // verdict and end of run
   task automatic final_report();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // one apb transfer: setup, then access until pready is sampled high
   task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int w;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr_n;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge clock);
         w++;
      end while (pready !== 1'b1 && w < 50);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   // register read compared with an expectation
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(what, r, exp);
      chk("slave error", {31'h0, e}, {31'h0, exp_err});
   endtask : rd_chk

   // reset held for ten clocks
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      n_resync = 0;
   endtask : do_reset

   // n bits, the first nerr in error, then settle and compare lock state
   task automatic send_bits(input int n, input int nerr, input logic exp_lock);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         bit_valid <= 1'b1;
         bit_err   <= (i < nerr);
      end
      @(posedge clock);
      bit_valid <= 1'b0;
      bit_err   <= 1'b0;
      repeat (4) @(negedge clock);
      chk("lock state", {31'h0, sync_locked}, {31'h0, exp_lock});
   endtask : send_bits

   // reset values, masks, read-only and unmapped places
   task automatic t_regs();
      rd_chk("ctrl reset", OFS_CTRL, CTRL_RST, 1'b0);
      rd_chk("dlen reset", OFS_DLEN, DLEN_RST, 1'b0);
      rd_chk("period reset", OFS_PERIOD, PERIOD_RST, 1'b0);
      rd_chk("unmapped", 8'h40, 32'h0000_0000, 1'b1);
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      rd_chk("status ro", OFS_STATUS, 32'h0000_0000, 1'b0);
      wr(OFS_CTRL, 32'hFFFF_FFFF);
      rd_chk("ctrl mask", OFS_CTRL, CTRL_WMASK, 1'b0);
      wr(OFS_CTRL, CTRL_RST);
   endtask : t_regs

   // table thresholds, short pattern gain row at its boundary
   task automatic t_table();
      send_bits(GAIN_W_A * WIN_UNIT, LIM_UNIT + 1, 1'b0);
      send_bits(GAIN_W_A * WIN_UNIT, LIM_UNIT, 1'b1);
   endtask : t_table

   // ten power minus two thresholds, auto realign on and off
   task automatic t_decimal();
      int win;
      win = DEC_LIM * DEC_BASE * DEC_BASE;
      @(posedge clock);
      do_reset();
      wr(OFS_CTRL, 32'h0000_0210);
      send_bits(win, 0, 1'b1);
      send_bits(win, DEC_LIM, 1'b1);
      send_bits(win, DEC_LIM + 1, 1'b0);
      chk("realign pulses", n_resync, 1);
      rd_chk("status count", OFS_STATUS, 32'h0000_0100, 1'b0);
      wr(OFS_CTRL, 32'h0000_0200);
      send_bits(win, DEC_LIM, 1'b1);
      send_bits(win, DEC_LIM + 1, 1'b0);
      chk("no realign", n_resync, 1);
   endtask : t_decimal

   // one result view over four reports; mode 0 running, 1 interval, 2 off
   task automatic run_view(input logic [31:0] ctrl, input int base, input int mode);
      int          c;
      int          k;
      logic [31:0] held;
      logic        moved;
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_PERIOD, 32'd3);
      wr(OFS_CTRL, ctrl);
      for (int i = 1; i <= 4; i++) begin
         c = 0;
         moved = 1'b0;
         held = result_clk;
         do begin
            @(negedge clock);
            c++;
            if (result_stb !== 1'b1 && result_clk !== held) moved = 1'b1;
         end while (result_stb !== 1'b1 && c < 500);
         if (result_stb !== 1'b1) errors++;
         k = (mode == 0) ? (i - 1) % 3 + 1 : (mode == 1) ? 1 : 3;
         if (i > 1) begin
            chk("report gap", c, (mode == 2) ? base * 3 : base);
            chk("result held", {31'h0, moved}, 32'h0000_0000);
         end
         chk("result clk", result_clk, base * k);
         chk("result err", result_err, base * k / 2);
      end
      rd_chk("rclk reg", OFS_RCLK, base * k, 1'b0);
      rd_chk("rerr reg", OFS_RERR, base * k / 2, 1'b0);
   endtask : run_view

   // main sequence
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
      bit_valid = 1'b0;
      bit_err = 1'b0;
      stream_on = 1'b0;
      errors = 0;
      n_tests = 0;
      n_resync = 0;
      do_reset();
      t_regs();
      t_table();
      t_decimal();
      stream_on <= 1'b1;
      run_view(32'h0000_0003, IV, 0);
      run_view(32'h0000_000F, 2 * IV, 1);
      run_view(32'h0000_0001, IV, 2);
      final_report();
   end

   // watchdog against a hang
   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      final_report();
   end
endmodule : tb_top
